// ===== logic/urswbg_pkg.sv
package urswbg_pkg;
    // ----------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_DIV_LO = 8'h04;
    localparam logic [7:0] OFF_DIV_HI = 8'h08;
    localparam logic [7:0] OFF_MOD    = 8'h0C;
    localparam logic [7:0] OFF_STAT   = 8'h10;
    localparam logic [7:0] OFF_MASK   = 8'h14;
    localparam logic [7:0] OFF_RXDAT  = 8'h18;

    // Control register fields
    localparam int CB_SSE   = 0;  // rx_start_edge_enable
    localparam int CB_RXIE  = 1;  // rx_irq_enable
    localparam int CB_GIE   = 2;  // global_irq_enable
    localparam int CB_EIE   = 3;  // rx_err_char_irq_enable
    localparam int CB_WIE   = 4;  // rx_wake_irq_enable
    localparam int CB_SWRST = 5;  // software reset of the serial unit
    localparam int CB_RUN   = 6;  // baud_source_clock running
    localparam int CTRL_W   = 7;
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

    // Sticky status fields, same layout in the mask register
    localparam int SB_START = 0;
    localparam int SB_CHAR  = 1;
    localparam int SB_ABORT = 2;
    localparam int SB_BREAK = 3;
    localparam int STAT_W   = 4;
    localparam logic [STAT_W-1:0] STAT_RST = 4'h0;

    // ----------------------------------------------------------------
    // Timing and framing
    // ----------------------------------------------------------------
    localparam int CLK_NS       = 100;
    localparam int DEGLITCH_NS  = 300;
    localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int IDLE_BITS    = 11;
    localparam int DATA_BITS    = 8;
    localparam int VOTE_NEED    = 2;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } urswbg_rx_e;
endpackage : urswbg_pkg

// ===== logic/urswbg_deglitch.sv
`timescale 1ns/100ps
module urswbg_deglitch import urswbg_pkg::*; #(
    parameter int LIM = DEGLITCH_CYC
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Raw pin and filtered level
    input  wire logic pin,
    output logic      filt_q
);
    localparam int CW = $clog2(LIM + 1);
    localparam logic [CW-1:0] CNT_TOP = CW'(LIM - 1);

    logic          s1_q;
    logic          s2_q;
    logic [CW-1:0] cnt_q;

    // Two-stage synchroniser, then a level must differ LIM cycles in a row
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q   <= 1'b1;
            s2_q   <= 1'b1;
            filt_q <= 1'b1;
            cnt_q  <= '0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            if (s2_q == filt_q) begin
                cnt_q <= '0;            // Glitch ends, count restarts
            end else if (cnt_q == CNT_TOP) begin
                filt_q <= s2_q;
                cnt_q  <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    chk_glitch_filter: assert property (
        @(posedge pclk) disable iff (!presetn)
        $changed(filt_q) |-> $past(cnt_q) == CNT_TOP && $past(s2_q) != $past(filt_q))
        else $error("filter output moved before deglitch time");
endmodule : urswbg_deglitch

// ===== logic/urswbg_baud.sv
`timescale 1ns/100ps
module urswbg_baud #(
    parameter int DIV_W = 16,
    parameter int MOD_W = 8
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Control
    input  wire logic             run,
    input  wire logic             restart,
    input  wire logic [DIV_W-1:0] divisor,
    input  wire logic [MOD_W-1:0] modpat,
    // Bit timing
    output logic                  smp,
    output logic                  bit_end
);
    localparam int IW = $clog2(MOD_W);

    logic [DIV_W:0]  cnt_q;
    logic [IW-1:0]   idx_q;
    logic [DIV_W:0]  len;
    logic [DIV_W:0]  half;

    // Bit length is the integer divisor plus the current pattern bit
    assign len  = {1'b0, divisor} + {{DIV_W{1'b0}}, modpat[idx_q]};
    assign half = {2'b00, divisor[DIV_W-1:1]};
    assign bit_end = run && (cnt_q == len - 1'b1);
    // Three samples around mid-bit for the vote; fits for divisor 3
    assign smp  = run && (cnt_q + 1'b1 == half || cnt_q == half
                          || cnt_q == half + 1'b1);

    // Divider counter and modulation pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            idx_q <= '0;
        end else if (restart) begin
            cnt_q <= '0;
            idx_q <= '0;
        end else if (!run) begin
            cnt_q <= '0;                // A frozen count could hit bit_end on restart
        end else if (bit_end) begin
            cnt_q <= '0;
            idx_q <= idx_q + 1'b1;
        end else if (run) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    chk_mod_first_bit: assert property (
        @(posedge pclk) disable iff (!presetn)
        restart |=> idx_q == '0 && cnt_q == '0)
        else $error("frame did not start on first pattern bit");

    chk_mod_step: assert property (
        @(posedge pclk) disable iff (!presetn)
        bit_end && !restart |=> idx_q == IW'($past(idx_q) + 1'b1))
        else $error("pattern pointer did not step once per bit");

    chk_bit_length: assert property (
        @(posedge pclk) disable iff (!presetn)
        bit_end |-> cnt_q + 1'b1 == {1'b0, divisor} + modpat[idx_q])
        else $error("bit period not divisor plus pattern bit");
endmodule : urswbg_baud

// ===== logic/urswbg_top.sv
// Functional notes
// - Falling edge on serial_rx_pin sets the start-detect flag.
// - Start flag requests service only with rx and global irq enables.
// - Receive pin is deglitched; short pulses set nothing, start nothing.
// - Failed start-bit majority vote abandons character, rx_irq_flag untouched.
// - With start-edge enable clear, start detect raises no request.
// - With error-char enable 0, erroneous characters leave rx_irq_flag.
// - Halted baud clock means no break detection.
// - Bit rates up to one third of the input clock.
// - Divider gives integer part, modulation the fraction.
// - Integer divisor is 16 bits from high and low bytes.
// - Modulation adjusts each bit of a frame separately.
// - Pattern starts at its lowest bit for the start bit.
// - Idle-line wake feature suppresses the receive flag and char status for insignificant characters; break still sets.
// - Set pattern bit lengthens the bit by one input cycle.
// - Pattern bits step m0 to m7 per bit, then wrap.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
module urswbg_top import urswbg_pkg::*; #(
    parameter int DEG_CYC = DEGLITCH_CYC
) (
    // APB clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial line
    input  wire logic        serial_rx_pin,
    // Requests to the system
    output logic             irq,
    output logic             rx_service_req
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_q;
    logic [7:0]        baud_divisor_low_q;
    logic [7:0]        baud_divisor_high_q;
    logic [7:0]        mod_q;
    logic [STAT_W-1:0] stat_q;
    logic [STAT_W-1:0] stat_d;
    logic [STAT_W-1:0] mask_q;
    logic [7:0]        rxbuf_q;
    logic              rx_irq_flag_q;
    logic              rx_start_detect_flag_q;
    logic              line_break_flag_q;
    logic              filt_d1_q;
    urswbg_rx_e        st_q;
    logic [2:0]        bcnt_q;
    logic [7:0]        sh_q;
    logic [1:0]        vcnt_q;
    logic [3:0]        idle_q;
    logic              wake_q;
    logic [31:0]       prdata_q;
    logic              pready_q;
    logic              pslverr_q;
    logic              irq_q;
    logic              req_q;

    assign prdata         = prdata_q;
    assign pready         = pready_q;
    assign pslverr        = pslverr_q;
    assign irq            = irq_q;
    assign rx_service_req = req_q;
    // ----------------------------------------------------------------
    // Control decode
    // ----------------------------------------------------------------
    logic        sse, rxie, global_irq_enable, eie, wie, swrst, run;
    logic [15:0] baud_divisor;

    assign sse   = ctrl_q[CB_SSE];
    assign rxie  = ctrl_q[CB_RXIE];
    assign global_irq_enable   = ctrl_q[CB_GIE];
    assign eie   = ctrl_q[CB_EIE];
    assign wie   = ctrl_q[CB_WIE];
    assign swrst = ctrl_q[CB_SWRST];
    // The sampling clock only runs while software lets it
    assign run   = ctrl_q[CB_RUN] && !swrst;
    assign baud_divisor = {baud_divisor_high_q, baud_divisor_low_q};

    // ----------------------------------------------------------------
    // Line filter and bit timing
    // ----------------------------------------------------------------
    logic rx_filt, fall, smp, bit_end, restart;

    urswbg_deglitch #(.LIM(DEG_CYC)) u_deglitch (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (serial_rx_pin),
        .filt_q  (rx_filt)
    );

    // Only a filtered edge counts, so glitches wake nothing
    assign fall    = filt_d1_q && !rx_filt;
    assign restart = (st_q == RX_IDLE) && fall && run;

    urswbg_baud #(.DIV_W(16), .MOD_W(8)) u_baud (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (run),
        .restart (restart),
        .divisor (baud_divisor),
        .modpat  (mod_q),
        .smp     (smp),
        .bit_end (bit_end)
    );

    // ----------------------------------------------------------------
    // Majority vote and character outcome
    // ----------------------------------------------------------------
    logic [1:0] vsum;
    logic       vote_one, char_done, fe, line_break_flag, take, abort;

    // Sample taken on the last count still joins the vote
    assign vsum      = vcnt_q + {1'b0, smp && rx_filt};
    assign vote_one  = vsum >= 2'(VOTE_NEED);
    assign abort     = (st_q == RX_START) && bit_end && vote_one;
    assign char_done = (st_q == RX_STOP) && bit_end;
    assign fe        = !vote_one;
    assign line_break_flag       = fe && (sh_q == 8'h00);
    // Errors need eie; with wie only idle-preceded characters count
    assign take = char_done && !(fe && !eie)
                  && !(wie && !wake_q);

    // ----------------------------------------------------------------
    // APB slave: one setup cycle, answer in the first access cycle
    // ----------------------------------------------------------------
    logic setup, acc, wr, rd;
    logic hit_ctrl, hit_lo, hit_hi, hit_mod, hit_stat, hit_mask, hit_dat;
    logic hit;
    logic [31:0] rdmux;

    assign setup = psel && !penable;
    assign acc   = psel && penable && pready_q;
    assign wr    = acc && pwrite;
    assign rd    = acc && !pwrite;

    assign hit_ctrl = paddr == OFF_CTRL;
    assign hit_lo   = paddr == OFF_DIV_LO;
    assign hit_hi   = paddr == OFF_DIV_HI;
    assign hit_mod  = paddr == OFF_MOD;
    assign hit_stat = paddr == OFF_STAT;
    assign hit_mask = paddr == OFF_MASK;
    assign hit_dat  = paddr == OFF_RXDAT;
    assign hit = hit_ctrl | hit_lo | hit_hi | hit_mod | hit_stat | hit_mask | hit_dat;

    // Read mux; RXDAT also shows the flags so software sees them together
    assign rdmux =
        hit_ctrl ? {25'h000_0000, ctrl_q} :
        hit_lo   ? {24'h00_0000, baud_divisor_low_q} :
        hit_hi   ? {24'h00_0000, baud_divisor_high_q} :
        hit_mod  ? {24'h00_0000, mod_q} :
        hit_stat ? {28'h000_0000, stat_q} :
        hit_mask ? {28'h000_0000, mask_q} :
        hit_dat  ? {21'h00_0000, line_break_flag_q, rx_start_detect_flag_q,
                    rx_irq_flag_q, rxbuf_q} :
        32'h0000_0000;

    // Bus answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q  <= pwrite ? 32'h0000_0000 : rdmux;
            pready_q  <= 1'b1;
            pslverr_q <= !hit;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // Software-written configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q              <= CTRL_RST;
            baud_divisor_low_q  <= 8'h00;
            baud_divisor_high_q <= 8'h00;
            mod_q               <= 8'h00;
            mask_q              <= STAT_RST;
        end else if (wr) begin
            if (hit_ctrl) ctrl_q <= pwdata[CTRL_W-1:0];
            if (hit_lo)   baud_divisor_low_q  <= pwdata[7:0];
            if (hit_hi)   baud_divisor_high_q <= pwdata[7:0];
            if (hit_mod)  mod_q  <= pwdata[7:0];
            if (hit_mask) mask_q <= pwdata[STAT_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Start detect, receive flag and service request
    // ----------------------------------------------------------------
    logic start_set;
    assign start_set = fall && sse && !swrst;

    // Start flag lives only while its enable is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_start_detect_flag_q <= 1'b0;
        end else if (swrst || !sse) begin
            rx_start_detect_flag_q <= 1'b0;
        end else if (start_set) begin
            rx_start_detect_flag_q <= 1'b1;
        end
    end

    // Receive flag: a new character wins over a same-cycle read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_irq_flag_q     <= 1'b0;
            line_break_flag_q <= 1'b0;
            rxbuf_q           <= 8'h00;
        end else if (swrst) begin
            rx_irq_flag_q     <= 1'b0;
            line_break_flag_q <= 1'b0;
        end else begin
            if (take) begin
                rx_irq_flag_q <= 1'b1;
                rxbuf_q       <= sh_q;
            end else if (rd && hit_dat) begin
                rx_irq_flag_q <= 1'b0;
            end
            if (char_done && line_break_flag && eie) begin
                line_break_flag_q <= 1'b1;
            end else if (rd && hit_dat) begin
                line_break_flag_q <= 1'b0;
            end
        end
    end

    // Request wakes the system; start flag drives it only while sse holds
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_q <= 1'b0;
            filt_d1_q <= 1'b1;          // Rests at idle level, no false edge after reset
        end else begin
            filt_d1_q <= rx_filt;
            req_q <= rxie && global_irq_enable && (rx_start_detect_flag_q || rx_irq_flag_q);
        end
    end

    // ----------------------------------------------------------------
    // Receive sequencer
    // ----------------------------------------------------------------
    // Stopping the clock drops any frame, so a break is never seen then
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q   <= RX_IDLE;
            bcnt_q <= 3'h0;
            sh_q   <= 8'h00;
            vcnt_q <= 2'h0;
            idle_q <= 4'h0;
            wake_q <= 1'b0;
        end else if (!run) begin
            st_q   <= RX_IDLE;
            vcnt_q <= 2'h0;
            idle_q <= 4'h0;
        end else begin
            vcnt_q <= bit_end ? 2'h0 : vsum;
            unique case (st_q)
                RX_IDLE: begin
                    if (fall) begin
                        st_q   <= RX_START;
                        wake_q <= idle_q == 4'(IDLE_BITS);
                        idle_q <= 4'h0;
                        vcnt_q <= 2'h0;
                    end else if (bit_end && rx_filt && idle_q != 4'(IDLE_BITS)) begin
                        idle_q <= idle_q + 4'h1;
                    end
                end
                RX_START: begin
                    if (bit_end) begin
                        st_q   <= vote_one ? RX_IDLE : RX_DATA;
                        bcnt_q <= 3'h0;
                    end
                end
                RX_DATA: begin
                    if (bit_end) begin
                        sh_q <= {vote_one, sh_q[7:1]};
                        if (bcnt_q == 3'(DATA_BITS - 1)) begin
                            st_q <= RX_STOP;
                        end else begin
                            bcnt_q <= bcnt_q + 3'h1;
                        end
                    end
                end
                RX_STOP: begin
                    if (bit_end) begin
                        st_q <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Sticky status, mask and interrupt line
    // ----------------------------------------------------------------
    logic [STAT_W-1:0] ev;
    logic [STAT_W-1:0] w1c;
    assign ev[SB_START] = start_set;
    assign ev[SB_CHAR]  = take;
    assign ev[SB_ABORT] = abort;
    assign ev[SB_BREAK] = char_done && line_break_flag && eie;
    assign w1c    = (wr && hit_stat) ? pwdata[STAT_W-1:0] : STAT_RST;
    // Event in the clearing cycle survives
    assign stat_d = (stat_q & ~w1c) | ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= STAT_RST;
            irq_q  <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq_q  <= |(stat_q & mask_q);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_start_flag_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        fall && sse && !swrst |=> rx_start_detect_flag_q ##1 req_q || !(rxie && global_irq_enable))
        else $error("falling edge did not set start flag");

    chk_req_gating: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(rxie && global_irq_enable) |=> !req_q)
        else $error("service request without both enables");

    chk_abort_clean: assert property (
        @(posedge pclk) disable iff (!presetn)
        abort |=> st_q == RX_IDLE && !$rose(rx_irq_flag_q) && stat_q[SB_ABORT])
        else $error("failed start bit not abandoned cleanly");

    chk_sse_off_quiet: assert property (
        @(posedge pclk) disable iff (!presetn)
        !sse |=> !rx_start_detect_flag_q)
        else $error("start flag alive with edge enable clear");

    chk_err_no_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        char_done && fe && !eie |=> !$rose(rx_irq_flag_q))
        else $error("erroneous character set receive flag");

    chk_halt_no_frame: assert property (
        @(posedge pclk) disable iff (!presetn)
        !run |=> st_q == RX_IDLE && !bit_end)
        else $error("receiver active with halted baud clock");

    chk_swrst_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        swrst |=> !rx_start_detect_flag_q && !rx_irq_flag_q)
        else $error("software reset left flags set");

    chk_wake_filter: assert property (
        @(posedge pclk) disable iff (!presetn)
        char_done && wie && !wake_q |=> !$rose(rx_irq_flag_q))
        else $error("insignificant character set receive flag");
endmodule : urswbg_top

// ===== bench/urswbg_tx_model.sv
`timescale 1ns/100ps
module urswbg_tx_model (
    // Clock
    input  wire logic pclk,
    // Serial line toward the receiver
    output logic      line
);
    // Line idles at mark level outside frames
    initial line = 1'b1;

    // One 8N1 frame, LSB first; bit i lasts div plus pattern bit i mod 8
    task automatic send(input logic [7:0] d, input logic stop, input int div,
                        input logic [7:0] md);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line <= f[i];
            repeat (div + int'(md[i % 8])) @(posedge pclk);
        end
        line <= 1'b1;
    endtask : send

    // Low pulse of n cycles, too short for a frame
    task automatic glitch(input int n);
        line <= 1'b0;
        repeat (n) @(posedge pclk);
        line <= 1'b1;
    endtask : glitch
endmodule : urswbg_tx_model

// ===== bench/urswbg_top_tb.sv
`timescale 1ns/100ps
module urswbg_top_tb import urswbg_pkg::*;;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic        serial_rx_pin, irq, rx_service_req, slv;
    int          error_cnt = 0;
    int          checks = 0;
    localparam int DIV = 259;

    // Clock of 100 ns period
    always #50 pclk = ~pclk;

    urswbg_top #(.DEG_CYC(DEGLITCH_CYC)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_rx_pin(serial_rx_pin),
        .irq(irq), .rx_service_req(rx_service_req));
    urswbg_tx_model tx_u (.pclk(pclk), .line(serial_rx_pin));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic tally_and_finish;
        $display("errors=%0d checks=%0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; the wait for pready is bounded
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        slv = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
        if (n >= 20) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdv & m, e);
    endtask : rd

    // Outputs are looked at mid-cycle, where they have settled
    task automatic pin(input logic s, input logic e);
        @(negedge pclk);
        chk({31'h0, s ? rx_service_req : irq}, {31'h0, e});
        @(posedge pclk);
    endtask : pin

    // ----------------------------------------------------------------
    // Hang guard
    // ----------------------------------------------------------------
    initial begin
        repeat (90000) @(posedge pclk);
        error_cnt++;
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 8'h00; pwdata = 32'h0000_0000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
        rd(OFF_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
        rd(OFF_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
        rd(8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
        chk({31'h0, slv}, 32'h0000_0001);
        // Divisor needs both bytes, well above the minimum of 3
        apb(1'b1, OFF_DIV_LO, 32'h0000_0003);
        apb(1'b1, OFF_DIV_HI, 32'h0000_0001);
        apb(1'b1, OFF_MOD, 32'h0000_006B);
        apb(1'b1, OFF_MASK, 32'h0000_0001);
        apb(1'b1, OFF_CTRL, 32'h0000_0047);
        tx_u.glitch(2);
        repeat (10) @(posedge pclk);
        rd(OFF_STAT, 32'h0000_000F, 32'h0000_0000);
        tx_u.send(8'hA5, 1'b1, DIV, 8'h6B);
        repeat (DIV) @(posedge pclk);
        rd(OFF_STAT, 32'h0000_0007, 32'h0000_0003);
        pin(1'b0, 1'b1);
        rd(OFF_RXDAT, 32'h0000_07FF, 32'h0000_03A5);
        pin(1'b1, 1'b1);
        apb(1'b1, OFF_CTRL, 32'h0000_0043);
        pin(1'b1, 1'b0);
        apb(1'b1, OFF_MASK, 32'h0000_0000);
        pin(1'b0, 1'b0);
        apb(1'b1, OFF_MASK, 32'h0000_0001);
        pin(1'b0, 1'b1);
        apb(1'b1, OFF_STAT, 32'h0000_0001);
        pin(1'b0, 1'b0);
        apb(1'b1, OFF_CTRL, 32'h0000_0046);
        rd(OFF_RXDAT, 32'h0000_0700, 32'h0000_0000);
        pin(1'b1, 1'b0);
        // Framing error with error-char enable off leaves buffer and flag
        tx_u.send(8'h5A, 1'b0, DIV, 8'h6B);
        repeat (DIV) @(posedge pclk);
        rd(OFF_RXDAT, 32'h0000_01FF, 32'h0000_00A5);
        // Edge that fails the start vote, then software reset
        apb(1'b1, OFF_CTRL, 32'h0000_0047);
        tx_u.glitch(8);
        repeat (400) @(posedge pclk);
        rd(OFF_STAT, 32'h0000_0004, 32'h0000_0004);
        rd(OFF_RXDAT, 32'h0000_0300, 32'h0000_0200);
        apb(1'b1, OFF_CTRL, 32'h0000_0067);
        rd(OFF_RXDAT, 32'h0000_0700, 32'h0000_0000);
        // Same edge with start-edge enable clear raises no start flag or request, only abort status
        apb(1'b1, OFF_CTRL, 32'h0000_0046);
        apb(1'b1, OFF_STAT, 32'h0000_000F);
        tx_u.glitch(8);
        repeat (400) @(posedge pclk);
        rd(OFF_RXDAT, 32'h0000_0300, 32'h0000_0000);
        pin(1'b1, 1'b0);
        // All-zero frame with a bad stop bit and error-char enable on
        apb(1'b1, OFF_CTRL, 32'h0000_004E);
        tx_u.send(8'h00, 1'b0, DIV, 8'h6B);
        repeat (DIV) @(posedge pclk);
        rd(OFF_RXDAT, 32'h0000_07FF, 32'h0000_0500);
        // Wake filter: only a character after a long idle line counts
        apb(1'b1, OFF_CTRL, 32'h0000_0056);
        repeat (12 * DIV) @(posedge pclk);
        tx_u.send(8'h11, 1'b1, DIV, 8'h6B);
        repeat (DIV) @(posedge pclk);
        rd(OFF_RXDAT, 32'h0000_01FF, 32'h0000_0111);
        tx_u.send(8'h22, 1'b1, DIV, 8'h6B);
        repeat (DIV) @(posedge pclk);
        rd(OFF_RXDAT, 32'h0000_01FF, 32'h0000_0011);
        tally_and_finish();
    end
endmodule : urswbg_top_tb
